// ---- pkg/rsx_pkg.sv ----
package rsx_pkg;

  // Operation select from the decoder
  typedef enum logic [3:0] {
    RSX_OP_NONE = 4'h0,
    RSX_OP_ROTL_CARRY = 4'h1, // rotate_left_through_carry
    RSX_OP_ROTR_CARRY = 4'h2, // rotate_right_through_carry
    RSX_OP_ROTR_PLAIN = 4'h3, // rotate_right_plain
    RSX_OP_SET_CARRY = 4'h4, // set_bit_op on carry
    RSX_OP_SET_BIT = 4'h5, // set_bit_op on addressed bit
    RSX_OP_SHORT_JUMP = 4'h6, // short_relative_jump
    RSX_OP_SUB_BORROW = 4'h7, // subtract_with_borrow
    RSX_OP_SWAP = 4'h8, // nibble swap
    RSX_OP_EXCH_FULL = 4'h9, // full_exchange
    RSX_OP_EXCH_DIGIT = 4'ha, // digit_exchange
    RSX_OP_XOR_ACC = 4'hb, // exclusive_or_op into accumulator
    RSX_OP_XOR_DIR = 4'hc // exclusive_or_op into direct byte
  } rsx_op_t;

  // Operand addressing modes
  typedef enum logic [1:0] {
    RSX_AM_REG  = 2'h0,
    RSX_AM_DIR  = 2'h1,
    RSX_AM_IND  = 2'h2,
    RSX_AM_IMM  = 2'h3
  } rsx_am_t;

  // Processor status bits
  typedef struct packed {
    logic carry;
    logic auxiliary_carry_flag;
    logic overflow_flag;
  } rsx_flags_t;

  // Request from the decoder
  typedef struct packed {
    rsx_op_t op;
    rsx_am_t mode;
    logic [7:0] acc;
    logic [7:0] operand;   // Register, RAM, direct or immediate value
    logic [7:0] port_latch;  // Output latch of a port destination
    logic dest_is_port;
    logic [7:0] disp;
    logic [15:0] pc;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    rsx_flags_t flags;
  } rsx_req_t;

  // Committed result
  typedef struct packed {
    logic acc_we;
    logic [7:0] acc;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_data;
    logic bit_we;
    logic [7:0] bit_addr;
    logic pc_we;
    logic [15:0] pc;
    rsx_flags_t flags;
  } rsx_res_t;

  localparam logic [15:0] RSX_JUMP_ADVANCE = 16'h0002;
  localparam logic [1:0] RSX_JUMP_CYCLES = 2'h2;
  localparam logic [1:0] RSX_ONE_CYCLE = 2'h1;
  localparam logic [7:0] RSX_ZERO_BYTE = 8'h00;
  localparam int RSX_NIB = 4;

endpackage

// ---- rtl/rsx_alu.sv ----
`timescale 1ns/100ps
// Functional notes
// - Rotate left through carry: A7 to carry, carry to A0, one cycle.
// - Rotate right through carry: A0 to carry, carry to A7, one cycle.
// - Set bit forces carry or addressed bit to one; one cycle.
// - Short jump target is PC plus two plus sign-extended displacement.
// - Short jump is unconditional and takes two cycles.
// - Subtract with borrow writes A minus carry minus source; carry is borrow.
// - Auxiliary carry set on borrow out of bit 3, else cleared.
// - Overflow is borrow into bit 7 xor borrow out of bit 7.
// - Subtract accepts register, direct, indirect, immediate; one cycle each.
// - Nibble swap exchanges accumulator halves, flags untouched.
// - Full exchange swaps accumulator and operand in one cycle.
// - Digit exchange swaps low nibbles with indirect RAM byte only.
// - Exclusive-or stores bitwise result in destination, flags untouched.
// - Accumulator destination takes any mode; direct takes accumulator or immediate.
// - Port destination uses output latch value, not pin levels.
module rsx_alu (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Decoder request
  input wire logic req_valid_i,
  input wire rsx_pkg::rsx_req_t req_i,
  // Commit
  output rsx_pkg::rsx_res_t res_o,
  output logic res_valid_o,
  output logic busy_o,
  output logic illegal_o
);
  typedef enum logic [1:0] {
    RSX_ST_IDLE = 2'b00,
    RSX_ST_JUMP = 2'b01
  } rsx_state_t;

  rsx_state_t state_q, state_d;
  rsx_pkg::rsx_res_t res_q, res_d, jump_q, jump_d;
  logic valid_q, valid_d, busy_q, busy_d, ill_q, ill_d;
  logic [7:0] sub_diff;
  logic sub_c, sub_aux, sub_ov;

  // Sign-extend the displacement and add to the advanced counter
  function automatic logic [15:0] rsx_rel_target(input logic [15:0] pc,
                                                input logic [7:0] rel);
    rsx_rel_target = pc + rsx_pkg::RSX_JUMP_ADVANCE + {{8{rel[7]}}, rel};
  endfunction

  // Nibble halves exchanged
  function automatic logic [7:0] rsx_swap_nib(input logic [7:0] v);
    rsx_swap_nib = {v[rsx_pkg::RSX_NIB-1:0], v[7:rsx_pkg::RSX_NIB]};
  endfunction

  rsx_borrow_sub u_borrow_sub (
    .acc_i(req_i.acc),
    .src_i(req_i.operand),
    .borrow_i(req_i.flags.carry),
    .diff_o(sub_diff),
    .carry_o(sub_c),
    .aux_o(sub_aux),
    .ovf_o(sub_ov)
  );

  // Operation decode and next state
  always_comb begin
    logic [7:0] xsrc;
    xsrc = req_i.operand;
    state_d = state_q;
    res_d = '0;
    res_d.flags = req_i.flags;
    jump_d = jump_q;
    valid_d = 1'b0;
    busy_d = 1'b0;
    ill_d = 1'b0;
    unique case (state_q)
      RSX_ST_IDLE: begin
        if (req_valid_i) begin
          valid_d = 1'b1;
          unique case (req_i.op)
            rsx_pkg::RSX_OP_ROTL_CARRY: begin
              res_d.acc_we = 1'b1;
              res_d.acc = {req_i.acc[6:0], req_i.flags.carry};
              res_d.flags.carry = req_i.acc[7];
            end
            rsx_pkg::RSX_OP_ROTR_CARRY: begin
              res_d.acc_we = 1'b1;
              res_d.acc = {req_i.flags.carry, req_i.acc[7:1]};
              res_d.flags.carry = req_i.acc[0];
            end
            rsx_pkg::RSX_OP_ROTR_PLAIN: begin
              res_d.acc_we = 1'b1;
              res_d.acc = {req_i.acc[0], req_i.acc[7:1]};
            end
            rsx_pkg::RSX_OP_SET_CARRY: begin
              res_d.flags.carry = 1'b1;
            end
            rsx_pkg::RSX_OP_SET_BIT: begin
              res_d.bit_we = 1'b1;
              res_d.bit_addr = req_i.addr;
            end
            rsx_pkg::RSX_OP_SHORT_JUMP: begin
              // Unconditional; commit on the second cycle
              valid_d = 1'b0;
              busy_d = 1'b1;
              jump_d = '0;
              jump_d.flags = req_i.flags;
              jump_d.pc_we = 1'b1;
              jump_d.pc = rsx_rel_target(req_i.pc, req_i.disp);
              state_d = RSX_ST_JUMP;
            end
            rsx_pkg::RSX_OP_SUB_BORROW: begin
              // Every addressing mode resolves to one operand byte
              res_d.acc_we = 1'b1;
              res_d.acc = sub_diff;
              res_d.flags.carry = sub_c;
              res_d.flags.auxiliary_carry_flag = sub_aux;
              res_d.flags.overflow_flag = sub_ov;
            end
            rsx_pkg::RSX_OP_SWAP: begin
              res_d.acc_we = 1'b1;
              res_d.acc = rsx_swap_nib(req_i.acc);
            end
            rsx_pkg::RSX_OP_EXCH_FULL: begin
              if (req_i.mode == rsx_pkg::RSX_AM_IMM) begin
                ill_d = 1'b1;
                valid_d = 1'b0;
              end else begin
                res_d.acc_we = 1'b1;
                res_d.acc = req_i.operand;
                res_d.mem_we = 1'b1;
                res_d.mem_addr = req_i.addr;
                res_d.mem_data = req_i.acc;
              end
            end
            rsx_pkg::RSX_OP_EXCH_DIGIT: begin
              if (req_i.mode != rsx_pkg::RSX_AM_IND) begin
                ill_d = 1'b1;
                valid_d = 1'b0;
              end else begin
                res_d.acc_we = 1'b1;
                res_d.acc = {req_i.acc[7:4], req_i.operand[3:0]};
                res_d.mem_we = 1'b1;
                res_d.mem_addr = req_i.addr;
                res_d.mem_data = {req_i.operand[7:4], req_i.acc[3:0]};
              end
            end
            rsx_pkg::RSX_OP_XOR_ACC: begin
              res_d.acc_we = 1'b1;
              res_d.acc = req_i.acc ^ req_i.operand;
            end
            rsx_pkg::RSX_OP_XOR_DIR: begin
              // Direct destination takes accumulator or immediate only
              if (req_i.mode != rsx_pkg::RSX_AM_REG && req_i.mode != rsx_pkg::RSX_AM_IMM) begin
                ill_d = 1'b1;
                valid_d = 1'b0;
              end else begin
                if (req_i.dest_is_port) begin
                  xsrc = req_i.port_latch;
                end
                res_d.mem_we = 1'b1;
                res_d.mem_addr = req_i.addr;
                // REG mode here means the accumulator is the mask
                res_d.mem_data = xsrc ^ ((req_i.mode == rsx_pkg::RSX_AM_REG) ?
                                 req_i.acc : req_i.disp);
              end
            end
            default: begin
              valid_d = 1'b0;
            end
          endcase
        end
      end
      RSX_ST_JUMP: begin
        res_d = jump_q;
        valid_d = 1'b1;
        state_d = RSX_ST_IDLE;
      end
      default: begin
        state_d = RSX_ST_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= RSX_ST_IDLE;
      res_q <= '0;
      jump_q <= '0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      state_q <= state_d;
      res_q <= res_d;
      jump_q <= jump_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
      ill_q <= ill_d;
    end
  end

  assign res_o = res_q;
  assign res_valid_o = valid_q;
  assign busy_o = busy_q;
  assign illegal_o = ill_q;

  // Checks
  a_rotl_carry_in: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_ROTL_CARRY |=>
    res_valid_o && res_o.acc == {$past(req_i.acc[6:0]), $past(req_i.flags.carry)}
    && res_o.flags.carry == $past(req_i.acc[7])) else $error("rotate left wrong");
  a_rotr_carry_in: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_ROTR_CARRY |=>
    res_o.acc == {$past(req_i.flags.carry), $past(req_i.acc[7:1])}
    && res_o.flags.carry == $past(req_i.acc[0])) else $error("rotate right wrong");
  a_set_carry_one: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_SET_CARRY |=>
    res_valid_o && res_o.flags.carry && !res_o.acc_we) else $error("set carry wrong");
  sequence s_jump_req;
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_SHORT_JUMP;
  endsequence
  sequence s_jump_commit;
    !res_valid_o && busy_o ##1 res_valid_o && res_o.pc_we;
  endsequence
  a_jump_two_cycles: assert property (@(posedge clk_i) disable iff (reset_i)
    s_jump_req |=> s_jump_commit) else $error("jump timing wrong");
  a_jump_target: assert property (@(posedge clk_i) disable iff (reset_i)
    s_jump_req |-> ##2 res_o.pc == $past(req_i.pc, 2) + 16'h0002
    + {{8{$past(req_i.disp[7], 2)}}, $past(req_i.disp, 2)}) else $error("jump target wrong");
  a_sub_result: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_SUB_BORROW |=>
    res_o.acc == $past(req_i.acc) - $past(req_i.operand) - {7'h00, $past(req_i.flags.carry)}
    && res_o.flags.carry == ({1'b0, $past(req_i.acc)} < {1'b0, $past(req_i.operand)}
    + {8'h00, $past(req_i.flags.carry)})) else $error("subtract wrong");
  a_sub_aux: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_SUB_BORROW |=>
    res_o.flags.auxiliary_carry_flag == ({1'b0, $past(req_i.acc[3:0])} <
    {1'b0, $past(req_i.operand[3:0])} + {4'h0, $past(req_i.flags.carry)}))
    else $error("aux wrong");
  a_swap_flags: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_SWAP |=>
    res_o.acc == {$past(req_i.acc[3:0]), $past(req_i.acc[7:4])}
    && res_o.flags == $past(req_i.flags)) else $error("swap wrong");
  a_digit_nibbles: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_EXCH_DIGIT
    && req_i.mode == rsx_pkg::RSX_AM_IND |=>
    res_o.mem_data == {$past(req_i.operand[7:4]), $past(req_i.acc[3:0])}
    && res_o.acc[7:4] == $past(req_i.acc[7:4])) else $error("digit exchange wrong");
  a_xor_port_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && state_q == RSX_ST_IDLE && req_i.op == rsx_pkg::RSX_OP_XOR_DIR
    && req_i.dest_is_port && req_i.mode == rsx_pkg::RSX_AM_IMM |=>
    res_o.mem_data == ($past(req_i.port_latch) ^ $past(req_i.disp)))
    else $error("port xor wrong");
endmodule

// ---- rtl/rsx_subtract_with_borrow.sv ----
`timescale 1ns/100ps
// Borrow subtract of accumulator minus carry minus source, with flag outputs
module rsx_borrow_sub (
  // Operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] src_i,
  input wire logic borrow_i,
  // Result
  output logic [7:0] diff_o,
  output logic carry_o,
  output logic aux_o,
  output logic ovf_o
);
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] low7;

  // Borrow chain taps at bits 3, 6 and 7
  always_comb begin
    full = {1'b0, acc_i} - {1'b0, src_i} - {8'h00, borrow_i};
    low = {1'b0, acc_i[3:0]} - {1'b0, src_i[3:0]} - {4'h0, borrow_i};
    low7 = {1'b0, acc_i[6:0]} - {1'b0, src_i[6:0]} - {7'h00, borrow_i};
    diff_o = full[7:0];
    carry_o = full[8];
    aux_o = low[4];
    ovf_o = full[8] ^ low7[7];
  end
endmodule

// ---- test/rsx_alu_tb.sv ----
`timescale 1ns/100ps
module rsx_alu_tb;
  // Stimulus, response and tallies
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  rsx_pkg::rsx_req_t req_i = '0;
  rsx_pkg::rsx_res_t res_o;
  rsx_pkg::rsx_res_t res;
  logic res_valid_o;
  logic busy_o;
  logic illegal_o;
  logic busy_seen;
  int fail_count = 0;
  int checked = 0;

  // Device under test
  rsx_alu i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .res_o(res_o), .res_valid_o(res_valid_o), .busy_o(busy_o), .illegal_o(illegal_o));

  // Core clock, 40 ns period
  always #20 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare a value up to 16 bits
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare a single flag
  task automatic chk_bit(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Request with neutral fields; carry clear, other flags set
  function automatic rsx_pkg::rsx_req_t mk(rsx_pkg::rsx_op_t op, rsx_pkg::rsx_am_t md,
      logic [7:0] a, logic [7:0] o);
    rsx_pkg::rsx_req_t r;
    r = '0;
    r.op = op;
    r.mode = md;
    r.acc = a;
    r.operand = o;
    r.addr = 8'h20;
    r.flags = 3'b011;
    return r;
  endfunction

  // One request, bounded wait for commit or refusal, latency check
  task automatic run_op(rsx_pkg::rsx_req_t r, logic [15:0] lat, logic bad);
    int n;
    n = 1;
    @(posedge clk_i);
    req_i <= r;
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    busy_seen = busy_o;
    while (res_valid_o !== 1'b1 && illegal_o !== 1'b1 && n < 5) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 5) begin
      fail_count++;
      end_of_test();
    end else begin
      res = res_o;
      chk_val("latency", lat, 16'(n));
      chk_bit("illegal", bad, illegal_o);
      chk_bit("commit", !bad, res_valid_o);
    end
  endtask

  // Single-cycle op with accumulator, memory and flag results
  task automatic op_chk(rsx_pkg::rsx_req_t r, logic aw, logic [7:0] ea, logic mw,
      logic [7:0] em, logic [2:0] ef);
    run_op(r, 16'(rsx_pkg::RSX_ONE_CYCLE), 1'b0);
    chk_bit("acc_we", aw, res.acc_we);
    if (aw) begin
      chk_val("acc", 16'(ea), 16'(res.acc));
    end
    chk_bit("mem_we", mw, res.mem_we);
    if (mw) begin
      chk_val("mem", 16'(em), 16'(res.mem_data));
      chk_val("mem_addr", 16'h0020, 16'(res.mem_addr));
    end
    chk_val("flags", 16'(ef), 16'(res.flags));
  endtask

  // Rotates, swap and set-bit forms
  task automatic t_acc_ops();
    rsx_pkg::rsx_op_t ops[4] = '{rsx_pkg::RSX_OP_ROTL_CARRY, rsx_pkg::RSX_OP_ROTR_CARRY,
      rsx_pkg::RSX_OP_ROTR_PLAIN, rsx_pkg::RSX_OP_SWAP};
    // Old carry of zero lands in bit 0 on the left rotate
    logic [7:0] ea[4] = '{8'h8a, 8'h62, 8'he2, 8'h5c};
    logic [2:0] ef[4] = '{3'b111, 3'b111, 3'b011, 3'b011};
    rsx_pkg::rsx_req_t r;
    for (int i = 0; i < 4; i++) begin
      op_chk(mk(ops[i], rsx_pkg::RSX_AM_REG, 8'hc5, 8'h00), 1'b1, ea[i], 1'b0, 8'h00, ef[i]);
    end
    r = mk(rsx_pkg::RSX_OP_ROTL_CARRY, rsx_pkg::RSX_AM_REG, 8'h45, 8'h00);
    r.flags = 3'b111;
    op_chk(r, 1'b1, 8'h8b, 1'b0, 8'h00, 3'b011);
    r.op = rsx_pkg::RSX_OP_ROTR_CARRY;
    r.acc = 8'h44;
    op_chk(r, 1'b1, 8'ha2, 1'b0, 8'h00, 3'b011);
    r = mk(rsx_pkg::RSX_OP_SET_CARRY, rsx_pkg::RSX_AM_REG, 8'hc5, 8'h00);
    op_chk(r, 1'b0, 8'h00, 1'b0, 8'h00, 3'b111);
    r.op = rsx_pkg::RSX_OP_SET_BIT;
    op_chk(r, 1'b0, 8'h00, 1'b0, 8'h00, 3'b011);
    chk_bit("bit_we", 1'b1, res.bit_we);
    chk_val("bit_addr", 16'h0020, 16'(res.bit_addr));
  endtask

  // Short jump across the displacement range
  task automatic t_jump();
    logic [7:0] dv[4] = '{8'h21, 8'hfe, 8'h80, 8'h7f};
    logic [15:0] pv[4] = '{16'h0123, 16'h0100, 16'h0082, 16'h0181};
    rsx_pkg::rsx_req_t r;
    for (int i = 0; i < 4; i++) begin
      r = mk(rsx_pkg::RSX_OP_SHORT_JUMP, rsx_pkg::RSX_AM_REG, 8'h00, 8'h00);
      r.pc = 16'h0100;
      r.disp = dv[i];
      run_op(r, 16'(rsx_pkg::RSX_JUMP_CYCLES), 1'b0);
      chk_bit("busy", 1'b1, busy_seen);
      chk_bit("pc_we", 1'b1, res.pc_we);
      chk_val("pc", pv[i], res.pc);
    end
  endtask

  // Reset in the middle of a short jump drops the pending commit
  task automatic t_reset();
    @(posedge clk_i);
    req_i <= mk(rsx_pkg::RSX_OP_SHORT_JUMP, rsx_pkg::RSX_AM_REG, 8'h00, 8'h00);
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    reset_i <= 1'b1;
    #1;
    chk_bit("reset jump busy", 1'b1, busy_o);
    @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk_bit("reset busy", 1'b0, busy_o);
    chk_bit("reset res", 1'b1, res_o == '0);
    @(posedge clk_i);
    #1;
    chk_bit("reset commit", 1'b0, res_valid_o);
    chk_bit("reset illegal", 1'b0, illegal_o);
  endtask

  // Borrow subtract with expected flags worked out bit by bit
  task automatic sub_case(rsx_pkg::rsx_am_t md, logic [7:0] a, logic [7:0] s, logic c);
    rsx_pkg::rsx_req_t r;
    logic [8:0] d;
    logic [2:0] fl;
    r = mk(rsx_pkg::RSX_OP_SUB_BORROW, md, a, s);
    r.flags = {c, 2'b11};
    d = {1'b0, a} - {1'b0, s} - 9'(c);
    fl[2] = d[8];
    fl[1] = {1'b0, a[3:0]} < ({1'b0, s[3:0]} + 5'(c));
    fl[0] = ({1'b0, a[6:0]} < ({1'b0, s[6:0]} + 8'(c))) ^ d[8];
    run_op(r, 16'h1, 1'b0);
    chk_val("sub acc", 16'(d[7:0]), 16'(res.acc));
    chk_val("sub flags", 16'(fl), 16'(res.flags));
  endtask

  // All source modes, then borrow and overflow corners
  task automatic t_sub();
    for (int m = 0; m < 4; m++) begin
      sub_case(rsx_pkg::rsx_am_t'(m), 8'hc9, 8'h54, 1'b1);
    end
    chk_val("sub example", 16'h0074, 16'(res.acc));
    chk_val("sub example flags", 16'h0001, 16'(res.flags));
    sub_case(rsx_pkg::RSX_AM_REG, 8'h00, 8'h01, 1'b0);
    sub_case(rsx_pkg::RSX_AM_IMM, 8'h80, 8'h01, 1'b0);
    sub_case(rsx_pkg::RSX_AM_DIR, 8'h10, 8'h0f, 1'b1);
  endtask

  // Exchanges and exclusive-or, legal and refused forms
  task automatic t_xfer();
    rsx_pkg::rsx_req_t r;
    for (int m = 0; m < 3; m++) begin
      r = mk(rsx_pkg::RSX_OP_EXCH_FULL, rsx_pkg::rsx_am_t'(m), 8'h3f, 8'h75);
      op_chk(r, 1'b1, 8'h75, 1'b1, 8'h3f, 3'b011);
    end
    r.mode = rsx_pkg::RSX_AM_IMM;
    run_op(r, 16'h1, 1'b1);
    r = mk(rsx_pkg::RSX_OP_EXCH_DIGIT, rsx_pkg::RSX_AM_IND, 8'h36, 8'h75);
    op_chk(r, 1'b1, 8'h35, 1'b1, 8'h76, 3'b011);
    r.mode = rsx_pkg::RSX_AM_DIR;
    run_op(r, 16'h1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      r = mk(rsx_pkg::RSX_OP_XOR_ACC, rsx_pkg::rsx_am_t'(m), 8'hc3, 8'haa);
      op_chk(r, 1'b1, 8'h69, 1'b0, 8'h00, 3'b011);
    end
    r = mk(rsx_pkg::RSX_OP_XOR_DIR, rsx_pkg::RSX_AM_REG, 8'hc3, 8'haa);
    op_chk(r, 1'b0, 8'h00, 1'b1, 8'h69, 3'b011);
    r.mode = rsx_pkg::RSX_AM_IMM;
    r.disp = 8'h31;
    op_chk(r, 1'b0, 8'h00, 1'b1, 8'h9b, 3'b011);
    r = mk(rsx_pkg::RSX_OP_XOR_DIR, rsx_pkg::RSX_AM_REG, 8'h01, 8'hff);
    r.dest_is_port = 1'b1;
    r.port_latch = 8'h34;
    op_chk(r, 1'b0, 8'h00, 1'b1, 8'h35, 3'b011);
    // Immediate mask on a port destination still starts from the latch
    r.mode = rsx_pkg::RSX_AM_IMM;
    r.disp = 8'h31;
    op_chk(r, 1'b0, 8'h00, 1'b1, 8'h05, 3'b011);
    for (int m = 1; m < 3; m++) begin
      r = mk(rsx_pkg::RSX_OP_XOR_DIR, rsx_pkg::rsx_am_t'(m), 8'hc3, 8'haa);
      run_op(r, 16'h1, 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk_bit("idle valid", 1'b0, res_valid_o);
    chk_bit("idle busy", 1'b0, busy_o);
    t_acc_ops();
    t_jump();
    t_reset();
    t_sub();
    t_xfer();
    end_of_test();
  end
endmodule
